// File: core/prct_consts.vh
// constants for the phy register access and cycle timer block
// assumes an axi4-lite slave with 32-bit data and byte addresses
`ifndef PRCT_CONSTS_VH
`define PRCT_CONSTS_VH
`define PRCT_OFF_PHY_ACCESS 8'hEC
`define PRCT_OFF_ISO_TIMER 8'hF0
`define PRCT_OFF_LINK_CTRL 8'hF4
`define PRCT_BIT_XFER_DONE 31
`define PRCT_BIT_RD_REQ 15
`define PRCT_BIT_WR_REQ 14
`define PRCT_BIT_SRC_SEL 2
`define PRCT_BIT_ROOT_ROLE 1
`define PRCT_BIT_TICK_EN 0
`define PRCT_OFFSET_WRAP 12'd3071
`define PRCT_COUNT_WRAP 13'd7999
`define PRCT_LINK_CTRL_RESET 32'h0000_0000
`define PRCT_TICK_NUM 32'd24576
`define PRCT_TICK_DEN 32'd100000
`endif

// File: core/prct_tick_gen.v
// fractional tick generator: one-cycle pulse at tick_num/tick_den of aclk
// assumes aclk at 100 MHz; the 24.576 MHz rate is built by accumulation
`timescale 1ns/1ns
`default_nettype none
`include "prct_consts.vh"
module prct_tick_gen #(
	parameter [31:0] TICK_NUM = `PRCT_TICK_NUM,
	parameter [31:0] TICK_DEN = `PRCT_TICK_DEN
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// tick out
	output reg tick
);
	reg [31:0] acc_q;
	wire [32:0] sum = {1'b0, acc_q} + {1'b0, TICK_NUM};
	// jitter of one aclk per tick is the price of not having a second clock
	always @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (sum >= {1'b0, TICK_DEN}) begin
			acc_q <= sum[31:0] - TICK_DEN;
			tick <= 1'b1;
		end else begin
			acc_q <= sum[31:0];
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: core/prct_sync.v
// three-stage synchroniser with agreement filter and rising-edge pulse
// assumes the input is asynchronous to aclk
`timescale 1ns/1ns
`default_nettype none
module prct_sync (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// pin and outputs
	input wire pin,
	output reg level,
	output wire rise
);
	reg s1_q, s2_q, s3_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				level <= s3_q;
		end
	end
	assign rise = (s2_q == s3_q) && s3_q && !level;
endmodule
`default_nettype wire

// File: core/prct_top.v
// phy register access unit and isochronous cycle timer with axi4-lite slave
// assumes a phy-link shim that turns requests into packets and reports
// register transfers and received cycle starts as one-cycle strobes
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "prct_consts.vh"

// Functional notes
// - set request clears transfer-complete flag
// - phy register transfer sets complete flag
// - bits 27-24 show last returned address
// - bits 23-16 show returned register data
// - read request sent then self-cleared
// - write request sent then self-cleared
// - bits 11-8 give target phy register
// - bits 7-0 write data, ignored on reads
// - reserved access bits read zero
// - master sends timer in cycle start
// - non-master loads timer from cycle start
// - timer free-runs when enabled without starts
// - seconds count rollovers modulo 128
// - cycle count wraps modulo 8000
// - offset counts ticks modulo 3072 on the internal source; on the external source it holds at 3071
// - external tick forces offset to zero
// - source select picks external or internal rollover
// - root master emits start at rollover
// - enable clear holds the offset
module prct_top (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// phy register request toward link shim
	output wire phy_req_valid,
	output wire phy_req_is_write,
	output reg [3:0] phy_req_index,
	output reg [7:0] phy_req_value,
	input wire phy_req_ready,
	// phy register transfer returned
	input wire phy_xfer_strobe,
	input wire [3:0] phy_xfer_index,
	input wire [7:0] phy_xfer_value,
	// cycle start traffic
	input wire node_is_root,
	input wire cs_rx_strobe,
	input wire [31:0] cs_rx_data,
	output reg cs_tx_strobe,
	output reg [31:0] cs_tx_data,
	// external 8 khz timing pin
	input wire external_period_input
);
	////////////////////////////////////////////////////////////////
	reg phy_xfer_complete_q;
	reg [3:0] returned_reg_index_q;
	reg [7:0] returned_reg_value_q;
	reg phy_read_request_q;
	reg phy_write_request_q;
	reg [3:0] target_reg_index_q;
	reg [7:0] outgoing_reg_value_q;
	reg [6:0] elapsed_seconds_field_q;
	reg [12:0] iso_period_counter_q;
	reg [11:0] sub_period_tick_counter_q;
	reg [31:0] link_ctrl_q;
	wire rollover_source_select = link_ctrl_q[`PRCT_BIT_SRC_SEL];
	wire timing_root_role = link_ctrl_q[`PRCT_BIT_ROOT_ROLE];
	wire tick_count_enable = link_ctrl_q[`PRCT_BIT_TICK_EN];

	// byte-lane merge, used by the phy access and timer registers; link control takes wr_data[2:0] without strobes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
		end
	endfunction

	// word-index decode, shared by the read and write paths
	function hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			hit = (addr[7:2] == off[7:2]);
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order
	reg aw_held_q, w_held_q;
	reg [7:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	wire aw_fire = s_axi_awvalid && s_axi_awready;
	wire w_fire = s_axi_wvalid && s_axi_wready;
	wire have_aw = aw_held_q || aw_fire;
	wire have_w = w_held_q || w_fire;
	wire wr_go = have_aw && have_w;
	wire [7:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
	wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
	wire [3:0] wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
	wire wr_phy = wr_go && hit(wr_addr, `PRCT_OFF_PHY_ACCESS);
	wire wr_tmr = wr_go && hit(wr_addr, `PRCT_OFF_ISO_TIMER);
	wire wr_ctl = wr_go && hit(wr_addr, `PRCT_OFF_LINK_CTRL);
	wire wr_ok = wr_phy || wr_tmr || wr_ctl;
	wire [31:0] phy_img = {phy_xfer_complete_q, 3'b000, returned_reg_index_q,
		returned_reg_value_q, phy_read_request_q, phy_write_request_q, 2'b00,
		target_reg_index_q, outgoing_reg_value_q};
	wire [31:0] phy_new = merge(phy_img, wr_data, wr_strb);
	wire [31:0] tmr_img = {elapsed_seconds_field_q, iso_period_counter_q,
		sub_period_tick_counter_q};
	wire [31:0] tmr_new = merge(tmr_img, wr_data, wr_strb);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (aw_fire && !wr_go) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_fire && !wr_go) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// read channel: one cycle to rdata, slverr on unmapped
	assign s_axi_arready = !s_axi_rvalid;
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			if (hit(s_axi_araddr, `PRCT_OFF_PHY_ACCESS))
				s_axi_rdata <= phy_img;
			else if (hit(s_axi_araddr, `PRCT_OFF_ISO_TIMER))
				s_axi_rdata <= tmr_img;
			else if (hit(s_axi_araddr, `PRCT_OFF_LINK_CTRL))
				s_axi_rdata <= {29'd0, link_ctrl_q[2:0]};
			else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'b10;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// phy register access
	// read wins if software breaks exclusivity; only one request goes out
	assign phy_req_valid = phy_read_request_q || phy_write_request_q;
	assign phy_req_is_write = !phy_read_request_q && phy_write_request_q;
	wire req_sent = phy_req_valid && phy_req_ready;
	wire set_req = wr_phy && (phy_new[`PRCT_BIT_RD_REQ] || phy_new[`PRCT_BIT_WR_REQ]);
	always @* begin
		phy_req_index = target_reg_index_q;
		phy_req_value = phy_req_is_write ? outgoing_reg_value_q : 8'h00;
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			phy_xfer_complete_q <= 1'b0;
			returned_reg_index_q <= 4'h0;
			returned_reg_value_q <= 8'h00;
			phy_read_request_q <= 1'b0;
			phy_write_request_q <= 1'b0;
			target_reg_index_q <= 4'h0;
			outgoing_reg_value_q <= 8'h00;
		end else begin
			// a returning transfer wins over the clearing request write
			if (phy_xfer_strobe) begin
				phy_xfer_complete_q <= 1'b1;
				returned_reg_index_q <= phy_xfer_index;
				returned_reg_value_q <= phy_xfer_value;
			end else if (set_req)
				phy_xfer_complete_q <= 1'b0;
			if (wr_phy && !req_sent) begin
				phy_read_request_q <= phy_new[`PRCT_BIT_RD_REQ];
				phy_write_request_q <= phy_new[`PRCT_BIT_WR_REQ];
			end else if (req_sent) begin
				phy_read_request_q <= 1'b0;
				phy_write_request_q <= 1'b0;
			end
			if (wr_phy) begin
				target_reg_index_q <= phy_new[11:8];
				outgoing_reg_value_q <= phy_new[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// cycle timer
	wire tick;
	wire ext_rise;
	prct_tick_gen u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick)
	);
	prct_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(external_period_input),
		.level(),
		.rise(ext_rise)
	);
	wire int_roll = tick && (sub_period_tick_counter_q == `PRCT_OFFSET_WRAP);
	wire roll = tick_count_enable && (rollover_source_select ? ext_rise : int_roll);
	wire is_master = timing_root_role && node_is_root;
	wire [12:0] cnt_inc = (iso_period_counter_q == `PRCT_COUNT_WRAP) ? 13'd0 :
		iso_period_counter_q + 13'd1;
	wire sec_step = iso_period_counter_q == `PRCT_COUNT_WRAP;

	always @(posedge aclk) begin
		if (!aresetn) begin
			elapsed_seconds_field_q <= 7'd0;
			iso_period_counter_q <= 13'd0;
			sub_period_tick_counter_q <= 12'd0;
			link_ctrl_q <= `PRCT_LINK_CTRL_RESET;
			cs_tx_strobe <= 1'b0;
			cs_tx_data <= 32'h0000_0000;
		end else begin
			cs_tx_strobe <= 1'b0;
			if (wr_ctl)
				link_ctrl_q <= {29'd0, wr_data[2:0]};
			if (wr_tmr) begin
				elapsed_seconds_field_q <= tmr_new[31:25];
				iso_period_counter_q <= tmr_new[24:12];
				sub_period_tick_counter_q <= tmr_new[11:0];
			end else if (cs_rx_strobe && !is_master) begin
				elapsed_seconds_field_q <= cs_rx_data[31:25];
				iso_period_counter_q <= cs_rx_data[24:12];
				sub_period_tick_counter_q <= cs_rx_data[11:0];
			end else if (roll) begin
				sub_period_tick_counter_q <= 12'd0;
				iso_period_counter_q <= cnt_inc;
				if (sec_step)
					elapsed_seconds_field_q <= elapsed_seconds_field_q + 7'd1;
				if (is_master) begin
					cs_tx_strobe <= 1'b1;
					cs_tx_data <= {elapsed_seconds_field_q + (sec_step ? 7'd1 : 7'd0),
						cnt_inc, 12'd0};
				end
			end else if (tick_count_enable && tick && !int_roll) begin
				sub_period_tick_counter_q <= sub_period_tick_counter_q + 12'd1;
			end
		end
	end
endmodule
`default_nettype wire

// File: verif/prct_top_props.sv
// port checker for the phy access and cycle timer block
// assumes binding onto prct_top, one aclk domain
`timescale 1ns/1ns
`default_nettype none
module prct_top_props (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// register bus
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	// phy request and cycle start
	input wire phy_req_valid,
	input wire phy_req_is_write,
	input wire [7:0] phy_req_value,
	input wire phy_req_ready,
	input wire node_is_root,
	input wire cs_tx_strobe,
	input wire [31:0] cs_tx_data
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////
a_req_taken: assert property (phy_req_valid && phy_req_ready |=> !phy_req_valid)
	else $error("request bit kept");
a_read_no_data: assert property (phy_req_valid && !phy_req_is_write |-> !phy_req_value)
	else $error("read carries data");
a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
	else $error("no read answer");
a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
	else $error("read answer stuck");
a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
	else $error("write answer stuck");
a_tx_pulse: assert property (cs_tx_strobe |=> !cs_tx_strobe)
	else $error("cycle start too long");
a_tx_fields: assert property (cs_tx_strobe |->
	cs_tx_data[11:0] == 12'h000 && cs_tx_data[24:12] < 13'h1F40)
	else $error("bad cycle start fields");
a_tx_root: assert property (cs_tx_strobe |-> $past(node_is_root))
	else $error("cycle start while not root");
endmodule
bind prct_top prct_top_props i_props (.*);
`default_nettype wire

// File: verif/prct_phy_model.sv
// phy model: takes register requests, answers each read with a transfer
// assumes one request at a time; the bench sets the acceptance delay
`timescale 1ns/1ns
`default_nettype none
module prct_phy_model (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// request
	input wire phy_req_valid,
	input wire phy_req_is_write,
	input wire [3:0] phy_req_index,
	input wire [7:0] phy_req_value,
	output logic phy_req_ready,
	// transfer
	output logic phy_xfer_strobe,
	output logic [3:0] phy_xfer_index,
	output logic [7:0] phy_xfer_value,
	// bench
	input wire [3:0] wait_cycles
);
logic [7:0] regs_q [16];
logic [3:0] cnt_q;
always @(posedge aclk) begin
	phy_req_ready <= 1'b0;
	phy_xfer_strobe <= 1'b0;
	// idle qualifiers toggle so a stale value never passes
	phy_xfer_index <= ~phy_xfer_index;
	phy_xfer_value <= ~phy_xfer_value;
	cnt_q <= 4'h0;
	if (!aresetn) begin
		phy_xfer_index <= 4'h0;
		phy_xfer_value <= 8'h00;
	end else if (phy_req_valid && phy_req_ready) begin
		if (phy_req_is_write) begin
			regs_q[phy_req_index] <= phy_req_value;
		end else begin
			phy_xfer_strobe <= 1'b1;
			phy_xfer_index <= phy_req_index;
			phy_xfer_value <= regs_q[phy_req_index];
		end
	end else if (phy_req_valid) begin
		cnt_q <= cnt_q + 4'h1;
		phy_req_ready <= cnt_q >= wait_cycles;
	end
end
endmodule
`default_nettype wire

// File: verif/prct_top_tb.sv
// bench for the phy access and cycle timer block
// assumes the phy model on the request side; checker comes in by bind
`timescale 1ns/1ns
`default_nettype none
module prct_top_tb;
logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
logic node_is_root = 1'b1, cs_rx_strobe = 1'b0, external_period_input = 1'b0;
logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, phy_req_value, phy_xfer_value;
logic [31:0] s_axi_wdata = 32'h0000_0000, cs_rx_data = 32'h0000_0000;
logic [31:0] s_axi_rdata, cs_tx_data, rd;
logic [3:0] s_axi_wstrb = 4'hF, wait_cycles = 4'h0, phy_req_index, phy_xfer_index;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic phy_req_valid, phy_req_is_write, phy_req_ready, phy_xfer_strobe, cs_tx_strobe;
integer fail_count = 0, check_count = 0;
always #5 aclk = ~aclk;
prct_top i_dut (.*);
prct_phy_model i_phy (.*);
////////////////////////////////////////
task automatic print_verdict;
	if (fail_count == 0 && check_count > 0) begin
		$display("*** PASS ***");
	end else begin
		$display("*** FAIL ***");
	end
	$finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	check_count++;
	if (got !== exp) begin
		fail_count++;
		$display("MISMATCH %0t got %h exp %h", $time, got, exp);
	end
endtask
// every wait ends here at the latest
task automatic bump(inout int n);
	n++;
	if (n > 20000) begin
		fail_count++;
		print_verdict;
	end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
	int n = 0;
	@(posedge aclk);
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	s_axi_bready <= 1'b1;
	do begin
		@(posedge aclk);
		if (s_axi_awready) s_axi_awvalid <= 1'b0;
		if (s_axi_wready) s_axi_wvalid <= 1'b0;
		bump(n);
	end while (s_axi_bvalid !== 1'b1);
	s_axi_bready <= 1'b0;
	chk({30'h0, s_axi_bresp}, {30'h0, er});
endtask
task automatic rdr(input logic [7:0] a, input logic [1:0] er);
	int n = 0;
	@(posedge aclk);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'b1;
	s_axi_rready <= 1'b1;
	do begin
		@(posedge aclk);
		if (s_axi_arready) s_axi_arvalid <= 1'b0;
		bump(n);
	end while (s_axi_rvalid !== 1'b1);
	rd = s_axi_rdata;
	s_axi_rready <= 1'b0;
	chk({30'h0, s_axi_rresp}, {30'h0, er});
endtask
task automatic poll(input int b, input logic v);
	int n = 0;
	do begin
		rdr(8'hEC, 2'b00);
		bump(n);
	end while (rd[b] !== v);
endtask
task automatic wait_tx(output int n);
	n = 0;
	do begin
		@(posedge aclk);
		bump(n);
	end while (cs_tx_strobe !== 1'b1);
endtask
// counts cycle start strobes over a fixed window
task automatic quiet(input int cycles, output int hits);
	hits = 0;
	repeat (cycles) begin
		@(posedge aclk);
		if (cs_tx_strobe !== 1'b0) hits++;
	end
endtask
// one received cycle start, then the timer must hold its fields
task automatic rx_load(input logic [31:0] d);
	@(posedge aclk);
	cs_rx_data <= d;
	cs_rx_strobe <= 1'b1;
	@(posedge aclk);
	cs_rx_strobe <= 1'b0;
	rdr(8'hF0, 2'b00);
	chk(rd & 32'hFFFF_F000, d);
endtask
////////////////////////////////////////
task automatic s_regs;
	rdr(8'hF4, 2'b00);
	chk(rd, 32'h0000_0000);
	rdr(8'h00, 2'b10);
	chk(rd, 32'h0000_0000);
	wr(8'h04, 32'hFFFF_FFFF, 2'b10);
	wr(8'hEC, 32'h7FFF_3A5C, 2'b00);
	rdr(8'hEC, 2'b00);
	chk(rd, 32'h0000_0A5C);
	// only byte 0 lands: the masked request bits must not start a transfer
	s_axi_wstrb <= 4'h1;
	wr(8'hEC, 32'hFFFF_FF33, 2'b00);
	s_axi_wstrb <= 4'hF;
	rdr(8'hEC, 2'b00);
	chk(rd, 32'h0000_0A33);
endtask
// prompt then slow phy, write then read, done flag cleared by a new request
task automatic s_phy;
	wr(8'hEC, 32'h0000_455A, 2'b00);
	poll(14, 1'b0);
	wait_cycles <= 4'h5;
	wr(8'hEC, 32'h0000_85FF, 2'b00);
	poll(31, 1'b1);
	chk(rd, 32'h855A_05FF);
	wr(8'hEC, 32'h0000_49C3, 2'b00);
	poll(14, 1'b0);
	chk(rd, 32'h055A_09C3);
	wr(8'hEC, 32'h0000_8900, 2'b00);
	poll(31, 1'b1);
	chk(rd, 32'h89C3_0900);
endtask
task automatic s_timer;
	int n;
	wr(8'hF0, 32'hFFF3_FBB8, 2'b00);
	repeat (20) @(posedge aclk);
	rdr(8'hF0, 2'b00);
	chk(rd, 32'hFFF3_FBB8);
	wr(8'hF4, 32'h0000_0003, 2'b00);
	wait_tx(n);
	chk(cs_tx_data, 32'h0000_0000);
	wait_tx(n);
	chk(cs_tx_data, 32'h0000_1000);
	// 3072 ticks at 24.576 of 100 cycles each is exactly 12500 cycles
	chk(n, 32'd12500);
	// longer than one internal cycle: only the pin may roll over
	wr(8'hF4, 32'h0000_0007, 2'b00);
	repeat (13000) @(posedge aclk);
	external_period_input <= 1'b1;
	wait_tx(n);
	external_period_input <= 1'b0;
	chk(cs_tx_data, 32'h0000_2000);
	rdr(8'hF0, 2'b00);
	chk(rd & 32'hFFFF_FFF0, 32'h0000_2000);
	// role bit alone is not enough: a node that is not root only listens
	node_is_root <= 1'b0;
	wr(8'hF4, 32'h0000_0003, 2'b00);
	rx_load(32'h1234_5000);
	quiet(13000, n);
	chk(n, 32'd0);
	rdr(8'hF0, 2'b00);
	chk(rd & 32'hFFFF_F000, 32'h1234_6000);
	node_is_root <= 1'b1;
	wr(8'hF4, 32'h0000_0001, 2'b00);
	rx_load(32'h0246_8000);
endtask
initial begin
	repeat (10) @(posedge aclk);
	aresetn <= 1'b1;
	s_regs;
	s_phy;
	s_timer;
	print_verdict;
end
endmodule
`default_nettype wire
